/* File: pkg/actf_pkg.sv */
package actf_pkg;

	localparam int CLK_NS = 10;
	localparam int CELL_CLK_NS = 80;
	localparam int PH_CYC = CELL_CLK_NS / CLK_NS;
	localparam int PH_W = $clog2(PH_CYC);
	localparam logic [PH_W-1:0] PH_LAST = PH_W'(PH_CYC - 1);
	localparam logic [PH_W-1:0] PH_HALF = PH_W'(PH_CYC / 2);

	// fifo reset strobe, a longest time: rounded down
	localparam int FRST_NS = 40;
	localparam int FRST_CYC_I = (FRST_NS / CLK_NS) < 1 ? 1 : FRST_NS / CLK_NS;
	localparam logic [3:0] FRST_CYC = 4'(FRST_CYC_I);

	// write strobe low time, a least time: rounded up
	localparam int WR_LOW_NS = 20;
	localparam int WR_LOW_I = (WR_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] WR_LOW_CYC = 4'(WR_LOW_I);

	localparam int CELL_LEN = 53;
	localparam int HDR_LEN = 5;
	localparam int PAY_LEN = 48;
	localparam logic [5:0] CELL_LAST = 6'(CELL_LEN - 1);
	localparam logic [5:0] PAY_FIRST = 6'(HDR_LEN);
	localparam int HDR_W = 8 * HDR_LEN;

	localparam logic [2:0] SEQ_PROG_FIRST = 3'h2;
	localparam logic [2:0] SEQ_PROG_LAST = 3'h5;
	localparam logic [2:0] SEQ_DONE = 3'h6;

	localparam logic [7:0] PROG_BYTE0 = 8'hf0;
	localparam logic [7:0] PROG_BYTE1 = 8'h70;
	localparam logic [7:0] PROG_BYTE2 = 8'h30;
	localparam logic [7:0] PROG_BYTE3 = 8'hd0;

	// default switch images, byte 0 in the low bits; hec byte left to
	// whoever sets the switches
	localparam logic [HDR_W-1:0] DEF_HDR_CTRL = 40'h00_40_00_80_00;
	localparam logic [HDR_W-1:0] DEF_HDR_DATA = 40'h00_80_00_80_00;

	typedef enum logic [1:0] {
		K_NULL = 2'b00,
		K_DATA = 2'b01,
		K_CTRL = 2'b11
	} actf_kind_e;

	typedef struct packed {
		logic wr_n;
		logic cd;
		logic [7:0] data;
	} actf_fifo_wr_s;

	typedef struct packed {
		logic board_rst;
		logic link_data_strobe;
		logic pkt_flag;
		logic ctrl_req;
		logic [7:0] byte_in;
		logic [HDR_W-1:0] sw_ctrl;
		logic [HDR_W-1:0] sw_data;
	} actf_pins_s;

	function automatic logic [7:0] actf_prog_byte(input logic [2:0] seq);
		case (seq)
			3'h2: return PROG_BYTE0;
			3'h3: return PROG_BYTE1;
			3'h4: return PROG_BYTE2;
			3'h5: return PROG_BYTE3;
			default: return 8'h00;
		endcase
	endfunction : actf_prog_byte

endpackage : actf_pkg

/* File: tb/actf_fifo_model.sv */
`timescale 1ns/10ps
module actf_fifo_model
	import actf_pkg::*;
(
	input wire logic clk,
	input wire actf_fifo_wr_s fw,
	input wire logic frst_n,
	input wire logic rd_n,
	output logic flag,
	output logic [31:0] prog,
	output int cnt
);
	logic wr_q = 1'b1;
	logic rd_q = 1'b1;
	logic lcd = 1'b0;
	logic [7:0] lat = 8'h00;
	int np = 0;
	initial begin
		cnt = 0;
		prog = 32'h0;
	end
	// byte and mode latched while strobe low, taken at its rise
	always @(posedge clk) begin
		wr_q <= fw.wr_n;
		rd_q <= rd_n;
		if (fw.wr_n === 1'b0) begin
			lat <= fw.data;
			lcd <= fw.cd;
		end
		if (frst_n === 1'b0) begin
			cnt <= 0;
			np <= 0;
		end else if (wr_q === 1'b0 && fw.wr_n === 1'b1) begin
			if (lcd) begin
				prog <= {prog[23:0], lat};
				np <= np + 1;
			end else
				cnt <= cnt + 1;
		end else if (rd_q === 1'b1 && rd_n === 1'b0 && cnt > 0)
			cnt <= cnt - 1;
	end
	assign flag = (np >= 4) && (cnt >= 48);
endmodule : actf_fifo_model

/* File: tb/actf_top_test.sv */
`timescale 1ns/10ps
module actf_top_test;
	import actf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic brd = 1'b0;
	logic stb = 1'b0;
	logic creq = 1'b0;
	logic [7:0] lb = 8'h00;
	// distinct headers, check byte filled in by hand
	logic [HDR_W-1:0] swc = {8'h3c, DEF_HDR_CTRL[31:0]};
	logic [HDR_W-1:0] swd = {8'hc3, DEF_HDR_DATA[31:0]};
	actf_fifo_wr_s fw;
	logic frst_n, rd_n, nul_n, hen, cs, flag;
	logic [7:0] hb;
	logic [1:0] kind;
	logic [31:0] prog;
	int cnt;
	int fails = 0;
	int cmp_count = 0;
	int cyc = 0;
	actf_top actf_top_inst (.REF_CLK(clk), .RESET_N(rst_n),
		.BOARD_RESET(brd), .LINK_DATA_STROBE(stb), .LINK_BYTE(lb),
		.FIFO_PACKET_FLAG(flag), .CTRL_CELL_REQ(creq), .HDR_SW_CTRL(swc),
		.HDR_SW_DATA(swd), .FIFO_WR(fw), .FIFO_RESET_STROBE_N(frst_n),
		.FIFO_RD_N(rd_n), .NULL_HEADER_ENABLE_N(nul_n), .HDR_EN(hen),
		.HDR_BYTE(hb), .CELL_START(cs), .CELL_KIND(kind));
	actf_fifo_model actf_fifo_model_inst (.clk(clk), .fw(fw), .frst_n(frst_n),
		.rd_n(rd_n), .flag(flag), .prog(prog), .cnt(cnt));
	initial forever #5 clk = ~clk;
	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			fails++;
			close_out;
		end
	end
	task chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task ws;
		int k;
		k = 0;
		step(1);
		while (cs !== 1'b1 && k < 1000) begin
			step(1);
			k++;
		end
	endtask : ws
	task hdr(input logic [HDR_W-1:0] sw);
		for (int n = 0; n < 5; n++) begin
			step(5);
			chk({hen, hb}, {1'b1, sw[8*n+:8]});
			step(3);
		end
	endtask : hdr
	task send(input logic [7:0] b);
		int k;
		k = 0;
		lb = b;
		stb = 1'b1;
		while (fw.wr_n !== 1'b0 && k < 8) begin
			step(1);
			k++;
		end
		chk(fw.data, b);
		stb = 1'b0;
		step(17);
	endtask : send
	task t_board;
		int lo, wlo, nl;
		lo = 0;
		wlo = 0;
		nl = 0;
		brd = 1'b1;
		for (int i = 0; i < 110; i++) begin
			step(1);
			lo += (frst_n === 1'b0);
			wlo += (fw.wr_n === 1'b0);
			nl += (i >= 100 && i < 108 && nul_n === 1'b0);
			// a link byte now must be refused
			stb = (i >= 80 && i < 85);
		end
		chk(lo, FRST_CYC_I);
		chk(wlo, 16);
		chk(prog, 32'hf0_70_30_d0);
		chk(nl, 4);
		chk(cnt, 0);
		brd = 1'b0;
		step(10);
		$display("test board reset done");
	endtask : t_board
	task t_data;
		int rl, len;
		rl = 0;
		len = 0;
		for (int i = 0; i < 48; i++)
			send(8'h11 + i[7:0]);
		chk({flag, 32'(cnt)}, {1'b1, 32'd48});
		ws;
		if (kind !== K_DATA)
			ws;
		chk(kind, K_DATA);
		hdr(swd);
		for (int i = 1; i <= 400; i++) begin
			step(1);
			rl += (rd_n === 1'b0);
			if (cs === 1'b1 && len == 0)
				len = i;
		end
		chk(len, 384);
		chk(rl, 192);
		chk(cnt, 0);
		$display("test data cell done");
	endtask : t_data
	task t_null;
		ws;
		chk(kind, K_NULL);
		for (int i = 0; i < 16; i++) begin
			chk({nul_n, hen}, {(i % 8) < 4, 1'b0});
			step(1);
		end
		$display("test null cell done");
	endtask : t_null
	task t_ctrl;
		creq = 1'b1;
		step(3);
		creq = 1'b0;
		ws;
		if (kind !== K_CTRL)
			ws;
		chk(kind, K_CTRL);
		hdr(swc);
		$display("test control cell done");
	endtask : t_ctrl
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		step(1);
		chk({hb, fw, frst_n, rd_n, nul_n, hen, cs, kind},
			{8'h00, 10'h200, 3'b111, 4'h0});
		$display("test reset values done");
		step(3);
		t_board;
		t_data;
		t_null;
		t_ctrl;
		close_out;
	end
endmodule : actf_top_test

/* File: verilog/actf_sync.sv */
`timescale 1ns/10ps
module actf_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : actf_sync

/* File: verilog/actf_top.sv */
`timescale 1ns/10ps
module actf_top (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic BOARD_RESET,
	input wire logic LINK_DATA_STROBE,
	input wire logic [7:0] LINK_BYTE,
	input wire logic FIFO_PACKET_FLAG,
	input wire logic CTRL_CELL_REQ,
	input wire logic [actf_pkg::HDR_W-1:0] HDR_SW_CTRL,
	input wire logic [actf_pkg::HDR_W-1:0] HDR_SW_DATA,
	output actf_pkg::actf_fifo_wr_s FIFO_WR,
	output logic FIFO_RESET_STROBE_N,
	output logic FIFO_RD_N,
	output logic NULL_HEADER_ENABLE_N,
	output logic HDR_EN,
	output logic [7:0] HDR_BYTE,
	output logic CELL_START,
	output logic [1:0] CELL_KIND
);
	import actf_pkg::*;

	actf_pins_s pins_raw, pins;
	logic brst_d, stb_d, brst_rise, stb_rise, tick, half2_n;
	logic [PH_W-1:0] ph_reg, ph_next;
	logic [2:0] seq_reg, seq_next;
	logic [5:0] cell_reg, cell_next;
	logic [3:0] frst_reg, frst_next, wr_reg, wr_next;
	logic ctrl_pend_reg;
	actf_kind_e kind_reg, kind_next;
	logic [HDR_W-1:0] hdr_word;

	assign pins_raw = '{board_rst: BOARD_RESET,
		link_data_strobe: LINK_DATA_STROBE,
		pkt_flag: FIFO_PACKET_FLAG, ctrl_req: CTRL_CELL_REQ,
		byte_in: LINK_BYTE, sw_ctrl: HDR_SW_CTRL, sw_data: HDR_SW_DATA};

	// byte and strobe share one synchroniser so they stay aligned
	actf_sync #(.W($bits(actf_pins_s))) u_sync (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.d(pins_raw),
		.q(pins)
	);

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			brst_d <= 1'b0;
			stb_d <= 1'b0;
		end else begin
			brst_d <= pins.board_rst;
			stb_d <= pins.link_data_strobe;
		end
	end
	assign brst_rise = pins.board_rst & ~brst_d;
	assign stb_rise = pins.link_data_strobe & ~stb_d;

	// 80 ns cycle built from phases of the reference clock
	assign tick = (ph_reg == PH_LAST);
	assign ph_next = tick ? '0 : ph_reg + PH_W'(1);
	assign half2_n = (ph_next >= PH_HALF);

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			ph_reg <= '0;
		else
			ph_reg <= ph_next;
	end

	// reset sequence counter
	always_comb begin
		seq_next = seq_reg;
		if (brst_rise)
			seq_next = '0;
		else if (pins.board_rst && tick && seq_reg != SEQ_DONE)
			seq_next = seq_reg + 3'h1;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			seq_reg <= SEQ_DONE;
		else
			seq_reg <= seq_next;
	end

	// short fifo-only reset at the start of every board reset
	assign frst_next = brst_rise ? FRST_CYC :
		(frst_reg != 4'h0 ? frst_reg - 4'h1 : 4'h0);

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			frst_reg <= 4'h0;
			FIFO_RESET_STROBE_N <= 1'b1;
		end else begin
			frst_reg <= frst_next;
			FIFO_RESET_STROBE_N <= (frst_next == 4'h0);
		end
	end

	// link writes are held off in reset so only the program lands there
	assign wr_next = (stb_rise && !pins.board_rst && frst_reg == 4'h0) ?
		WR_LOW_CYC : (wr_reg != 4'h0 ? wr_reg - 4'h1 : 4'h0);

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			wr_reg <= 4'h0;
		else
			wr_reg <= wr_next;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			FIFO_WR <= '{wr_n: 1'b1, cd: 1'b0, data: 8'h00};
		end else if (pins.board_rst) begin
			// byte stands whole count, strobe low only in its second half
			if (seq_next >= SEQ_PROG_FIRST && seq_next <= SEQ_PROG_LAST) begin
				FIFO_WR.cd <= 1'b1;
				FIFO_WR.data <= actf_prog_byte(seq_next);
				FIFO_WR.wr_n <= ~half2_n;
			end else begin
				FIFO_WR <= '{wr_n: 1'b1, cd: 1'b0, data: 8'h00};
			end
		end else begin
			FIFO_WR.cd <= 1'b0;
			FIFO_WR.wr_n <= (wr_next == 4'h0);
			if (wr_next != 4'h0 && wr_reg == 4'h0)
				FIFO_WR.data <= pins.byte_in;
		end
	end

	// cell sequencer keeps running through board reset
	assign cell_next = !tick ? cell_reg :
		(cell_reg == CELL_LAST ? 6'h00 : cell_reg + 6'h01);

	always_comb begin
		kind_next = kind_reg;
		if (tick && cell_reg == CELL_LAST) begin
			if (pins.board_rst)
				kind_next = K_NULL;
			else if (ctrl_pend_reg)
				kind_next = K_CTRL;
			else if (pins.pkt_flag)
				kind_next = K_DATA;
			else
				kind_next = K_NULL;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			cell_reg <= CELL_LAST;
			kind_reg <= K_NULL;
		end else begin
			cell_reg <= cell_next;
			kind_reg <= kind_next;
		end
	end

	// request set wins over the clear when a control cell starts
	always_ff @(posedge REF_CLK) begin
		if (!RESET_N)
			ctrl_pend_reg <= 1'b0;
		else if (pins.ctrl_req)
			ctrl_pend_reg <= 1'b1;
		else if (tick && cell_reg == CELL_LAST && kind_next == K_CTRL)
			ctrl_pend_reg <= 1'b0;
	end

	// switch lines carry on=0 as read, switch 8 on bit 7 of each byte
	assign hdr_word = (kind_next == K_CTRL) ? pins.sw_ctrl : pins.sw_data;

	always_ff @(posedge REF_CLK) begin
		if (!RESET_N) begin
			NULL_HEADER_ENABLE_N <= 1'b1;
			HDR_EN <= 1'b0;
			HDR_BYTE <= 8'h00;
			FIFO_RD_N <= 1'b1;
			CELL_START <= 1'b0;
			CELL_KIND <= K_NULL;
		end else begin
			NULL_HEADER_ENABLE_N <= ~(half2_n &&
				(kind_next == K_NULL || pins.board_rst));
			HDR_EN <= half2_n && kind_next != K_NULL &&
				!pins.board_rst && cell_next < PAY_FIRST;
			// payload counts show zero, never a byte past the header
			HDR_BYTE <= (cell_next < PAY_FIRST) ?
				hdr_word[8*cell_next[2:0] +: 8] : 8'h00;
			FIFO_RD_N <= ~(half2_n && kind_next == K_DATA &&
				!pins.board_rst && cell_next >= PAY_FIRST);
			CELL_START <= tick && cell_next == 6'h00;
			CELL_KIND <= kind_next;
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RESET_N);

	a_rst_strobe_len: assert property (brst_rise |=>
		!FIFO_RESET_STROBE_N [*4] ##1 FIFO_RESET_STROBE_N)
		else $error("fifo reset strobe length wrong");
	a_prog_byte_val: assert property (!FIFO_WR.wr_n && FIFO_WR.cd |->
		FIFO_WR.data == actf_prog_byte(seq_reg))
		else $error("wrong programming byte");
	a_prog_only_rst: assert property (FIFO_WR.cd |-> $past(pins.board_rst))
		else $error("programming outside reset");
	a_no_early_prog: assert property (pins.board_rst &&
		seq_reg < SEQ_PROG_FIRST && !brst_rise |=> FIFO_WR.wr_n)
		else $error("write on count 0 or 1");
	a_link_write: assert property (stb_rise && !pins.board_rst &&
		frst_reg == 4'h0 && wr_reg == 4'h0 |=> !FIFO_WR.wr_n [*2] ##1
		(FIFO_WR.wr_n || $past(stb_rise)))
		else $error("link write strobe shape wrong");
	a_link_byte: assert property (stb_rise && !pins.board_rst &&
		frst_reg == 4'h0 && wr_reg == 4'h0 |=> FIFO_WR.data ==
		$past(pins.byte_in) ##1 $stable(FIFO_WR.data))
		else $error("written byte not held");
	a_null_half: assert property (!NULL_HEADER_ENABLE_N |->
		ph_reg >= PH_HALF) else $error("null enable in first half");
	a_null_in_rst: assert property ($past(pins.board_rst) &&
		ph_reg >= PH_HALF |-> !NULL_HEADER_ENABLE_N)
		else $error("no null cell during reset");
	a_cell_wrap: assert property (tick && cell_reg == CELL_LAST |=>
		cell_reg == 6'h00 && CELL_START)
		else $error("cell not 53 counts");
	a_flag_sample: assert property (tick && cell_reg == CELL_LAST &&
		pins.pkt_flag && !pins.board_rst && !ctrl_pend_reg |=>
		kind_reg == K_DATA) else $error("flag not sampled");
	a_ctrl_clear: assert property (tick && cell_reg == CELL_LAST &&
		kind_next == K_CTRL && !pins.ctrl_req |=> !ctrl_pend_reg)
		else $error("control request not cleared");
	a_seq_step: assert property (pins.board_rst && tick &&
		seq_reg < SEQ_DONE && !brst_rise |=> seq_reg == $past(seq_reg) + 3'h1)
		else $error("sequence did not step");

	c_prog_last: cover property (!FIFO_WR.wr_n && FIFO_WR.cd &&
		seq_reg == SEQ_PROG_LAST);
	c_data_cell: cover property (CELL_START && CELL_KIND == K_DATA);
	c_ctrl_cell: cover property (CELL_START && CELL_KIND == K_CTRL);
	c_link_write: cover property (!FIFO_WR.wr_n && !FIFO_WR.cd);
endmodule : actf_top
